// [stage_pkg.sv]
// constants, field layout and types of the undercurrent stage
package stage_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int CYCLE_MS = 5;
  localparam int PRE_TRIG_MS = 20;
  localparam int PREFAULT_MS = 200;
  localparam int HIST_DEPTH = PREFAULT_MS / CYCLE_MS;
  localparam int PRE_IDX = PRE_TRIG_MS / CYCLE_MS - 1;
  localparam int PFLT_IDX = HIST_DEPTH - 1;
  localparam int REC_DEPTH = 12;
  localparam int HYST_NUM = 103;
  localparam int HYST_DEN = 100;
  localparam int CUR_WIDTH = 16;
  localparam int DLY_W = 21;
  localparam int CNT_WIDTH = 16;
  localparam int ADDR_W = 8;
  // byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EVSEL = 8'h04;
  localparam logic [7:0] OFS_ISET = 8'h08;
  localparam logic [7:0] OFS_NOLOAD = 8'h0C;
  localparam logic [7:0] OFS_DELAY = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_EXPTIME = 8'h18;
  localparam logic [7:0] OFS_CNT_START = 8'h1C;
  localparam logic [7:0] OFS_CNT_TRIP = 8'h20;
  localparam logic [7:0] OFS_CNT_BLK = 8'h24;
  localparam logic [7:0] OFS_CNTCLR = 8'h28;
  localparam logic [7:0] OFS_CLOCK = 8'h2C;
  localparam logic [7:0] OFS_RECSEL = 8'h30;
  localparam logic [7:0] OFS_REC_TIME = 8'h34;
  localparam logic [7:0] OFS_REC_INFO = 8'h38;
  localparam logic [7:0] OFS_REC_PRE = 8'h3C;
  localparam logic [7:0] OFS_REC_FLT = 8'h40;
  localparam logic [7:0] OFS_REC_PFLT = 8'h44;
  localparam logic [7:0] OFS_REC_REM = 8'h48;
  // control fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FORCE_EN = 3;
  localparam int CTRL_FORCE_LSB = 4;
  // reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [5:0] EVSEL_RST = 6'h3F;
  localparam logic [15:0] ISET_RST = 16'h0032;
  localparam logic [15:0] NOLOAD_RST = 16'h0014;
  localparam logic [20:0] DELAY_RST = 21'h0003E8;
  // event codes
  localparam logic [2:0] EV_START_ON = 3'h0;
  localparam logic [2:0] EV_TRIP_ON = 3'h2;
  localparam logic [2:0] EV_BLK_ON = 3'h4;
  typedef enum logic [2:0] {
    MODE_ON = 3'h0, MODE_BLOCKED = 3'h1, MODE_TEST = 3'h2, MODE_TEST_BLK = 3'h3, MODE_OFF = 3'h4
  } mode_t;
  typedef enum logic [1:0] {
    COND_NORMAL = 2'h0, COND_START = 2'h1, COND_TRIP = 2'h2, COND_BLOCKED = 2'h3
  } cond_t;
endpackage : stage_pkg

// [count_if.sv]
// counter request and value bundle
interface count_if #(parameter int W = 16) ();
  logic inc;
  logic clr;
  logic [W-1:0] value;
  modport counter (input inc, input clr, output value);
  modport user (output inc, output clr, input value);
endinterface : count_if

// [phase_compare.sv]
// per-phase pick-up and release comparison
module phase_compare import stage_pkg::*; #(
  parameter int CUR_W = CUR_WIDTH
) (
  // current and setting
  input wire logic [CUR_W-1:0] i_cur,
  input wire logic [CUR_W-1:0] i_set,
  // results
  output logic o_below,
  output logic o_released
);
  logic [CUR_W+6:0] cur_x;
  logic [CUR_W+6:0] rel_x;
  assign cur_x = (CUR_W+7)'(i_cur) * (CUR_W+7)'(HYST_DEN);
  assign rel_x = (CUR_W+7)'(i_set) * (CUR_W+7)'(HYST_NUM);
  assign o_below = i_cur < i_set;
  assign o_released = cur_x > rel_x;
endmodule : phase_compare

// [event_counter.sv]
// cumulative event counter with clear
module event_counter #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // request and value
  count_if.counter c
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (c.inc) begin
      cnt_q <= c.clr ? W'(1) : cnt_q + W'(1);
    end else if (c.clr) begin
      cnt_q <= '0;
    end
  end
  assign c.value = cnt_q;
endmodule : event_counter

// [undercurrent_stage.sv]
// undercurrent stage status, timing, events, counters and fault records
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
module undercurrent_stage import stage_pkg::*; #(
  parameter int MS_CYCLES = MS_CYCLES_DEF,
  parameter int CNT_W = CNT_WIDTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // measurement, blocking and setting group
  input wire logic [CUR_WIDTH-1:0] i_cur_l1,
  input wire logic [CUR_WIDTH-1:0] i_cur_l2,
  input wire logic [CUR_WIDTH-1:0] i_cur_l3,
  input wire logic i_block,
  input wire logic [2:0] i_setting_group,
  // stage outputs
  output logic o_start,
  output logic o_trip,
  output logic o_blocked,
  // event buffer
  output logic o_evt_valid,
  output logic [2:0] o_evt_code,
  output logic [31:0] o_evt_time
);
  localparam int DIV_W = $clog2(MS_CYCLES + 1);

  // time base
  logic [DIV_W-1:0] ms_div_q;
  logic [2:0] cyc_q;
  logic [31:0] clock_q;
  logic ms_tick;
  logic prog_tick;
  logic eval_q;
  assign ms_tick = ms_div_q == DIV_W'(MS_CYCLES - 1);
  assign prog_tick = ms_tick && (cyc_q == 3'(CYCLE_MS - 1));
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ms_div_q <= '0;
      cyc_q <= '0;
      eval_q <= 1'b0;
    end else begin
      ms_div_q <= ms_tick ? '0 : ms_div_q + DIV_W'(1);
      cyc_q <= prog_tick ? '0 : (ms_tick ? cyc_q + 3'h1 : cyc_q);
      eval_q <= prog_tick;
    end
  end

  // bus handshake and write strobes
  logic [31:0] wmask;
  logic wr_en;
  logic [5:0] ctrl_q;
  logic [5:0] evsel_q;
  logic [15:0] iset_q;
  logic [15:0] noload_q;
  logic [DLY_W-1:0] delay_q;
  logic [3:0] recsel_q;
  assign wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                  {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  assign wr_en = i_write && !o_waitrequest;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction : merge
  wire hit_ctrl = i_address == OFS_CTRL;
  wire hit_evsel = i_address == OFS_EVSEL;
  wire hit_iset = i_address == OFS_ISET;
  wire hit_noload = i_address == OFS_NOLOAD;
  wire hit_delay = i_address == OFS_DELAY;
  wire hit_status = i_address == OFS_STATUS;
  wire hit_exptime = i_address == OFS_EXPTIME;
  wire hit_cs = i_address == OFS_CNT_START;
  wire hit_ct = i_address == OFS_CNT_TRIP;
  wire hit_cb = i_address == OFS_CNT_BLK;
  wire hit_cntclr = i_address == OFS_CNTCLR;
  wire hit_clock = i_address == OFS_CLOCK;
  wire hit_recsel = i_address == OFS_RECSEL;
  wire hit_rtime = i_address == OFS_REC_TIME;
  wire hit_rinfo = i_address == OFS_REC_INFO;
  wire hit_rpre = i_address == OFS_REC_PRE;
  wire hit_rflt = i_address == OFS_REC_FLT;
  wire hit_rpflt = i_address == OFS_REC_PFLT;
  wire hit_rrem = i_address == OFS_REC_REM;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q <= CTRL_RST;
      evsel_q <= EVSEL_RST;
      iset_q <= ISET_RST;
      noload_q <= NOLOAD_RST;
      delay_q <= DELAY_RST;
      recsel_q <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_q <= 6'(merge({26'h0, ctrl_q}, i_writedata, wmask));
      if (hit_evsel) evsel_q <= 6'(merge({26'h0, evsel_q}, i_writedata, wmask));
      if (hit_iset) iset_q <= 16'(merge({16'h0, iset_q}, i_writedata, wmask));
      if (hit_noload) noload_q <= 16'(merge({16'h0, noload_q}, i_writedata, wmask));
      if (hit_delay) delay_q <= DLY_W'(merge({11'h0, delay_q}, i_writedata, wmask));
      if (hit_recsel) recsel_q <= 4'(merge({28'h0, recsel_q}, i_writedata, wmask));
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      clock_q <= '0;
    end else if (wr_en && hit_clock) begin
      clock_q <= merge(clock_q, i_writedata, wmask);
    end else if (ms_tick) begin
      clock_q <= clock_q + 32'h1;
    end
  end

  // mode and forcing settings
  logic [2:0] mode;
  logic force_en;
  logic [1:0] force_st;
  logic mode_off;
  logic blk_mode;
  logic io_en;
  assign mode = ctrl_q[CTRL_MODE_LSB +: 3];
  assign force_en = ctrl_q[CTRL_FORCE_EN];
  assign force_st = ctrl_q[CTRL_FORCE_LSB +: 2];
  assign mode_off = mode >= MODE_OFF;
  assign blk_mode = (mode == MODE_BLOCKED) || (mode == MODE_TEST_BLK);
  assign io_en = force_en || (mode == MODE_ON);

  // phase comparison
  logic [2:0] below;
  logic [2:0] rel;
  logic [CUR_WIDTH-1:0] cur [3];
  assign cur[0] = i_cur_l1;
  assign cur[1] = i_cur_l2;
  assign cur[2] = i_cur_l3;
  for (genvar g = 0; g < 3; g++) begin : g_ph
    phase_compare #(.CUR_W(CUR_WIDTH)) u_cmp (
      .i_cur(cur[g]),
      .i_set(iset_q),
      .o_below(below[g]),
      .o_released(rel[g])
    );
  end
  wire [CUR_WIDTH-1:0] min01 = (cur[0] < cur[1]) ? cur[0] : cur[1];
  wire [CUR_WIDTH-1:0] cur_min = (min01 < cur[2]) ? min01 : cur[2];
  wire [CUR_WIDTH-1:0] max01 = (cur[0] > cur[1]) ? cur[0] : cur[1];
  wire [CUR_WIDTH-1:0] cur_max = (max01 > cur[2]) ? max01 : cur[2];

  // program cycle sampling and history
  logic blk_q;
  logic lock_q;
  logic [2:0] below_q;
  logic [2:0] rel_q;
  logic [CUR_WIDTH-1:0] cur_min_q;
  logic [CUR_WIDTH-1:0] hist_q [HIST_DEPTH];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      blk_q <= 1'b0;
      lock_q <= 1'b1;
      below_q <= '0;
      rel_q <= '0;
      cur_min_q <= '0;
      for (int i = 0; i < HIST_DEPTH; i++) hist_q[i] <= '0;
    end else if (prog_tick) begin
      blk_q <= i_block;
      lock_q <= cur_max < noload_q;
      below_q <= below;
      rel_q <= rel;
      cur_min_q <= cur_min;
      hist_q[0] <= cur_min_q;
      for (int i = 1; i < HIST_DEPTH; i++) hist_q[i] <= hist_q[i-1];
    end
  end

  // pick-up hysteresis and definite delay state machine
  logic pick_q;
  logic pick_d;
  logic blk_eff;
  cond_t state_q;
  cond_t state_d;
  logic [DLY_W-1:0] elapsed_q;
  logic [CUR_WIDTH-1:0] prefault_q;
  assign blk_eff = blk_q || blk_mode;
  assign pick_d = lock_q ? 1'b0 : (|below_q ? 1'b1 : (&rel_q ? 1'b0 : pick_q));
  always_comb begin
    state_d = state_q;
    case (state_q)
      COND_NORMAL: begin
        if (pick_d && blk_eff) state_d = COND_BLOCKED;
        else if (pick_d) state_d = COND_START;
      end
      COND_START: begin
        if (!pick_d) state_d = COND_NORMAL;
        else if (blk_eff) state_d = COND_BLOCKED;
        else if (elapsed_q >= delay_q) state_d = COND_TRIP;
      end
      COND_TRIP: begin
        if (!pick_d) state_d = COND_NORMAL;
        else if (blk_eff) state_d = COND_BLOCKED;
      end
      COND_BLOCKED: begin
        if (!pick_d) state_d = COND_NORMAL;
        else if (!blk_eff) state_d = COND_START;
      end
      default: state_d = COND_NORMAL;
    endcase
    if (mode_off) state_d = COND_NORMAL;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= COND_NORMAL;
      pick_q <= 1'b0;
      elapsed_q <= '0;
      prefault_q <= '0;
    end else begin
      if (eval_q) begin
        state_q <= state_d;
        pick_q <= pick_d;
        if (state_q == COND_NORMAL && pick_d) prefault_q <= hist_q[PFLT_IDX];
      end
      if (eval_q && state_d == COND_START && state_q != COND_START) begin
        elapsed_q <= '0;
      end else if (ms_tick && state_q == COND_START && elapsed_q != '1) begin
        elapsed_q <= elapsed_q + DLY_W'(1);
      end
    end
  end
  wire [DLY_W-1:0] remaining = (state_q == COND_START) ? delay_q - elapsed_q : '0;
  wire [DLY_W-1:0] exp_time = (state_q == COND_START) ? remaining : delay_q;

  // effective condition, forcing and event generation
  logic [1:0] cond;
  logic [2:0] flags;
  logic [2:0] flags_prev_q;
  logic [5:0] pend_q;
  logic [5:0] new_ev;
  logic [5:0] serve;
  logic [2:0] emit_idx;
  logic emit_any;
  assign cond = force_en ? force_st : state_q;
  assign flags = {cond == COND_BLOCKED, cond == COND_TRIP,
                  (cond == COND_START) || (cond == COND_TRIP)};
  for (genvar g = 0; g < 3; g++) begin : g_ev
    assign new_ev[2*g] = flags[g] && !flags_prev_q[g];
    assign new_ev[2*g+1] = !flags[g] && flags_prev_q[g];
  end
  always_comb begin
    emit_idx = '0;
    emit_any = 1'b0;
    for (int i = 5; i >= 0; i--) begin
      if (pend_q[i]) begin
        emit_idx = 3'(i);
        emit_any = 1'b1;
      end
    end
  end
  assign serve = emit_any ? (6'h01 << emit_idx) : 6'h00;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags_prev_q <= '0;
      pend_q <= '0;
      o_evt_valid <= 1'b0;
      o_evt_code <= '0;
      o_evt_time <= '0;
      o_start <= 1'b0;
      o_trip <= 1'b0;
      o_blocked <= 1'b0;
    end else begin
      flags_prev_q <= flags;
      pend_q <= (pend_q & ~serve) | new_ev;
      o_evt_valid <= emit_any && evsel_q[emit_idx];
      o_evt_code <= emit_idx;
      o_evt_time <= clock_q;
      o_start <= flags[0] && io_en;
      o_trip <= flags[1] && io_en;
      o_blocked <= flags[2] && io_en;
    end
  end

  // cumulative counters
  logic [2:0] cnt_clr;
  logic [CNT_W-1:0] cnt_val [3];
  assign cnt_clr = (wr_en && hit_cntclr) ? (i_writedata[2:0] & {3{i_byteenable[0]}}) : 3'h0;
  for (genvar g = 0; g < 3; g++) begin : g_cnt
    count_if #(.W(CNT_W)) cif ();
    assign cif.inc = emit_any && !emit_idx[0] && (emit_idx[2:1] == 2'(g));
    assign cif.clr = cnt_clr[g];
    assign cnt_val[g] = cif.value;
    event_counter #(.W(CNT_W)) u_cnt (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .c(cif.counter)
    );
  end

  // fault record store
  logic [3:0] rec_wp_q;
  logic [3:0] rec_cnt_q;
  logic [31:0] rec_time [REC_DEPTH];
  logic [10:0] rec_info [REC_DEPTH];
  logic [CUR_WIDTH-1:0] rec_pre [REC_DEPTH];
  logic [CUR_WIDTH-1:0] rec_flt [REC_DEPTH];
  logic [CUR_WIDTH-1:0] rec_pflt [REC_DEPTH];
  logic [DLY_W-1:0] rec_rem [REC_DEPTH];
  wire rec_wr = emit_any && !emit_idx[0];
  wire [4:0] rd_raw = {1'b0, rec_wp_q} + 5'(REC_DEPTH - 1) - {1'b0, recsel_q};
  wire [3:0] rd_ix = (rd_raw >= 5'(REC_DEPTH)) ? 4'(rd_raw - 5'(REC_DEPTH)) : rd_raw[3:0];
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rec_wp_q <= '0;
      rec_cnt_q <= '0;
    end else if (rec_wr) begin
      rec_wp_q <= (rec_wp_q == 4'(REC_DEPTH - 1)) ? 4'h0 : rec_wp_q + 4'h1;
      if (rec_cnt_q != 4'(REC_DEPTH)) rec_cnt_q <= rec_cnt_q + 4'h1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (rec_wr) begin
      rec_time[rec_wp_q] <= clock_q;
      rec_info[rec_wp_q] <= {i_setting_group, 1'b0, below_q, 2'b00, emit_idx[2:1]};
      rec_pre[rec_wp_q] <= hist_q[PRE_IDX];
      rec_flt[rec_wp_q] <= cur_min_q;
      rec_pflt[rec_wp_q] <= prefault_q;
      rec_rem[rec_wp_q] <= remaining;
    end
  end
  wire rec_ok = recsel_q < rec_cnt_q;

  // read mux and answer
  wire [31:0] status_word = {24'h0, blk_q, lock_q, pick_q, mode, cond};
  wire [31:0] rd_mux =
      ({32{hit_ctrl}} & {26'h0, ctrl_q}) |
      ({32{hit_evsel}} & {26'h0, evsel_q}) |
      ({32{hit_iset}} & {16'h0, iset_q}) |
      ({32{hit_noload}} & {16'h0, noload_q}) |
      ({32{hit_delay}} & {11'h0, delay_q}) |
      ({32{hit_status}} & status_word) |
      ({32{hit_exptime}} & {11'h0, exp_time}) |
      ({32{hit_cs}} & {16'h0, cnt_val[0]}) |
      ({32{hit_ct}} & {16'h0, cnt_val[1]}) |
      ({32{hit_cb}} & {16'h0, cnt_val[2]}) |
      ({32{hit_clock}} & clock_q) |
      ({32{hit_recsel}} & {20'h0, rec_cnt_q, 4'h0, recsel_q}) |
      ({32{hit_rtime && rec_ok}} & rec_time[rd_ix]) |
      ({32{hit_rinfo && rec_ok}} & {21'h0, rec_info[rd_ix]}) |
      ({32{hit_rpre && rec_ok}} & {16'h0, rec_pre[rd_ix]}) |
      ({32{hit_rflt && rec_ok}} & {16'h0, rec_flt[rd_ix]}) |
      ({32{hit_rpflt && rec_ok}} & {16'h0, rec_pflt[rd_ix]}) |
      ({32{hit_rrem && rec_ok}} & {11'h0, rec_rem[rd_ix]});
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_waitrequest <= 1'b1;
      o_readdata <= '0;
    end else begin
      o_waitrequest <= !((i_read || i_write) && o_waitrequest);
      if (i_read && o_waitrequest) o_readdata <= rd_mux;
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  blk_sample_hold_a: assert property (!prog_tick |=> $stable(blk_q))
    else $error("blocking sample changed outside program cycle start");
  start_entry_a: assert property (
    (eval_q && !mode_off && state_q == COND_NORMAL && pick_d && !blk_eff)
      |=> state_q == COND_START && elapsed_q == '0)
    else $error("pick-up without blocking did not start");
  blocked_entry_a: assert property (
    (eval_q && !mode_off && state_q == COND_NORMAL && pick_d && blk_eff)
      |=> state_q == COND_BLOCKED)
    else $error("pick-up with blocking did not block");
  start_release_a: assert property (
    (eval_q && state_q == COND_START && blk_eff) |=> state_q != COND_START)
    else $error("start held while blocked");
  trip_delay_a: assert property (
    (state_q == COND_TRIP && $past(state_q) == COND_START) |-> $past(elapsed_q) >= delay_q)
    else $error("trip before operate delay");
  noload_lock_a: assert property ((eval_q && lock_q) |=> !pick_q && state_q == COND_NORMAL)
    else $error("stage active while locked");
  event_gate_a: assert property (
    o_evt_valid |-> $past(emit_any) && o_evt_code == $past(emit_idx) && $past(evsel_q[emit_idx]))
    else $error("event written without selection");
  start_event_a: assert property ((flags[0] && !flags_prev_q[0]) |=> pend_q[0] ##[0:6] $fell(pend_q[0]))
    else $error("start on event not emitted");
  counter_step_a: assert property (
    (rec_wr && emit_idx == EV_TRIP_ON && !cnt_clr[1]) |=> cnt_val[1] == $past(cnt_val[1]) + CNT_W'(1))
    else $error("trip counter did not step");
  record_depth_a: assert property (rec_cnt_q <= 4'(REC_DEPTH) && rec_wp_q < 4'(REC_DEPTH))
    else $error("record store overflow");
  force_trip_a: assert property (
    (force_en && force_st == COND_TRIP)[*2] |-> o_trip && o_start && !o_blocked)
    else $error("forced trip not shown");
  mode_off_a: assert property ((mode_off && !force_en)[*2] |-> !o_start && !o_trip)
    else $error("outputs active in off mode");
  trip_seen_c: cover property (state_q == COND_START ##1 state_q == COND_TRIP);
  block_seen_c: cover property (state_q == COND_START ##1 state_q == COND_BLOCKED);
  store_full_c: cover property (rec_wr && rec_cnt_q == 4'(REC_DEPTH));
  off_event_c: cover property (o_evt_valid && o_evt_code[0]);
endmodule : undercurrent_stage

// [stage_partner.sv]
// blocking source and event buffer model
module stage_partner (
  // clock
  input wire logic i_clk,
  // blocking request and line
  input wire logic i_block_req,
  output logic o_block,
  // event buffer
  input wire logic i_evt_valid,
  input wire logic [2:0] i_evt_code,
  input wire logic [31:0] i_evt_time,
  output logic [5:0][7:0] o_seen,
  output logic [5:0][31:0] o_stamp
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_block = 1'b0;
    o_seen = '0;
    o_stamp = '0;
  end
  always @(posedge i_clk) begin
    o_block <= i_block_req;
    if (i_evt_valid === 1'b1 && i_evt_code < 3'h6) begin
      o_seen[i_evt_code] <= o_seen[i_evt_code] + 8'h01;
      o_stamp[i_evt_code] <= i_evt_time;
    end
  end
endmodule : stage_partner

// [testbench.sv]
// self-checking bench of the undercurrent stage
module testbench import stage_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_address = 8'h00;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic [15:0] cur = 16'h0064;
  logic [15:0] cur_b = 16'h0064;
  logic blk_req = 1'b0;
  logic blk;
  logic o_start, o_trip, o_blocked, o_evt_valid;
  logic [2:0] o_evt_code;
  logic [31:0] o_evt_time, rd;
  logic [5:0][7:0] seen;
  logic [5:0][31:0] stamp;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  undercurrent_stage #(.MS_CYCLES(10)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(4'hF), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_cur_l1(cur), .i_cur_l2(cur_b), .i_cur_l3(cur_b), .i_block(blk),
    .i_setting_group(3'h2), .o_start(o_start), .o_trip(o_trip), .o_blocked(o_blocked),
    .o_evt_valid(o_evt_valid), .o_evt_code(o_evt_code), .o_evt_time(o_evt_time));
  stage_partner partner (.i_clk(i_clk), .i_block_req(blk_req), .o_block(blk),
    .i_evt_valid(o_evt_valid), .i_evt_code(o_evt_code), .i_evt_time(o_evt_time),
    .o_seen(seen), .o_stamp(stamp));
  always #50 i_clk = ~i_clk;
  task report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
    checks++;
    if (seen_v !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen_v);
    end
  endtask : check
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= ~wr;
    do @(posedge i_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask : bus
  task wait_out(input int sel, input logic v);
    for (int n = 0; n < 400; n++) begin
      @(posedge i_clk);
      if (((({o_blocked, o_trip, o_start} >> sel) & 3'h1) == {2'b00, v})) break;
    end
  endtask : wait_out
  task t_regs();
    bus(1'b0, OFS_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    bus(1'b0, OFS_EVSEL, 32'h0);
    check("evsel", rd, 32'h3F);
    bus(1'b0, OFS_DELAY, 32'h0);
    check("delay", rd, 32'h3E8);
    bus(1'b0, 8'hFC, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask : t_regs
  task t_lock();
    cur <= 16'h000A;
    cur_b <= 16'h000A;
    repeat (160) @(posedge i_clk);
    check("locked start", o_start, 1'b0);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("lock flag", rd[6], 1'b1);
  endtask : t_lock
  task t_trip();
    bus(1'b1, OFS_DELAY, 32'h14);
    cur <= 16'h0028;
    cur_b <= 16'h0064;
    wait_out(0, 1'b1);
    check("start", o_start, 1'b1);
    repeat (100) @(posedge i_clk);
    check("early trip", o_trip, 1'b0);
    wait_out(1, 1'b1);
    check("trip", o_trip, 1'b1);
    bus(1'b0, OFS_CNT_TRIP, 32'h0);
    check("trip count", rd, 32'h1);
    check("stamp gap", stamp[2] - stamp[0], 32'h14);
    bus(1'b0, OFS_RECSEL, 32'h0);
    check("record count", rd[11:8], 4'h2);
    bus(1'b0, OFS_REC_INFO, 32'h0);
    check("newest record", rd[10:0], 11'h211);
  endtask : t_trip
  task t_release();
    cur <= 16'h0033;
    repeat (160) @(posedge i_clk);
    check("held start", o_start, 1'b1);
    cur <= 16'h0034;
    wait_out(0, 1'b0);
    check("released", {o_start, o_trip}, 2'b00);
    repeat (6) @(posedge i_clk);
    check("events", {seen[3], seen[2], seen[1], seen[0]}, 32'h01010101);
  endtask : t_release
  task t_block();
    bus(1'b1, OFS_EVSEL, 32'h2F);
    blk_req <= 1'b1;
    repeat (60) @(posedge i_clk);
    cur <= 16'h0028;
    wait_out(2, 1'b1);
    check("blocked", {o_blocked, o_start}, 2'b10);
    bus(1'b0, OFS_CNT_BLK, 32'h0);
    check("blocked count", rd, 32'h1);
    check("masked event", seen[4], 8'h00);
    blk_req <= 1'b0;
    wait_out(0, 1'b1);
    check("unblocked start", {o_blocked, o_start}, 2'b01);
    blk_req <= 1'b1;
    wait_out(0, 1'b0);
    check("start dropped", {o_blocked, o_start}, 2'b10);
    bus(1'b1, OFS_CNTCLR, 32'h7);
    bus(1'b0, OFS_CNT_START, 32'h0);
    check("cleared", rd, 32'h0);
  endtask : t_block
  task t_modes();
    bus(1'b1, OFS_CTRL, 32'h28);
    repeat (3) @(posedge i_clk);
    check("forced trip", {o_blocked, o_trip, o_start}, 3'b011);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("forced status", rd[1:0], 2'h2);
    bus(1'b1, OFS_CTRL, 32'h4);
    repeat (60) @(posedge i_clk);
    check("off outputs", {o_blocked, o_trip, o_start}, 3'b000);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("off status", rd[7:0], 8'hB0);
    bus(1'b0, OFS_EXPTIME, 32'h0);
    check("expected time", rd, 32'h14);
  endtask : t_modes
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    t_regs();
    t_lock();
    t_trip();
    t_release();
    t_block();
    t_modes();
    report_and_stop();
  end
endmodule : testbench
